// ==== src/ram_cfg.svh ====
/*
  Constants of the configurable embedded memory block: geometry, register
  offsets, field positions, reset values and codes.
  Assumes it is included by bare name, once per compilation unit.
*/
// Functional notes
// RULE1 - user keeps w times m times n within capacity
// RULE2 - user keeps w times n within widest port
// RULE3 - shift mode offers taps of configurable length, width
// RULE4 - last tap leaves block for chaining further blocks
// RULE5 - rom loaded at configuration, port writes ignored
// RULE6 - rom address always captured in a register
// RULE7 - rom output registered or direct, by option
// RULE8 - rom read timed like single-port read
// RULE9 - fifo with shared or split side enables
// RULE10 - user avoids read plus write on empty fifo
// RULE11 - async clear only on read address, outputs
// RULE12 - legal clocking modes checked per memory mode
// RULE13 - independent mode: each port on own enable
// RULE14 - independent mode: port enable gates that port only
// RULE15 - io mode: input enable gates all input registers
// RULE16 - io mode: output enable gates only data outputs
// RULE17 - io mode: per port input and output enables
// RULE18 - rw mode: write side gates write registers
// RULE19 - rw mode: read side gates read registers
// RULE20 - rw mode: read and write enables separate
// RULE21 - single-clock mode: all registers one enable
// RULE22 - same-port and mixed-port collisions told apart
// RULE23 - same-port collision shows new or old data
// RULE24 - shared-clock mixed collision shows old or undefined
// RULE25 - split-enable mixed collision shows undefined
// RULE26 - outputs start at zero despite preloaded array
// RULE27 - each shift advances all segments one word
`ifndef RAM_BLOCK_CFG_SVH
`define RAM_BLOCK_CFG_SVH

`define RAM_DW          36
`define RAM_AW          8
`define RAM_DEPTH       256
`define RAM_CNTW        9
`define RAM_BITS        9216
`define RAM_LAST_IDX    8'hff
`define RAM_FULL_CNT    9'h100

// apb map
`define RAM_PAW         12
`define RAM_OFF_CTRL    12'h000
`define RAM_OFF_SHCFG   12'h004
`define RAM_OFF_STATUS  12'h008
`define RAM_OFF_PTR     12'h00c

// control fields
`define RAM_CTRL_MODE   2:0
`define RAM_CTRL_CLK    4:3
`define RAM_CTRL_OREG   5
`define RAM_CTRL_NEWD   6
`define RAM_CTRL_MOLD   7
`define RAM_CTRL_EN     8
`define RAM_CTRL_RST    32'h0000_0118

// shift geometry fields
`define RAM_SH_W        5:0
`define RAM_SH_N        13:8
`define RAM_SH_M        24:16
`define RAM_SHCFG_RST   32'h0010_0408

// status fields
`define RAM_ST_BUSY     0
`define RAM_ST_CFGERR   1
`define RAM_ST_EMPTY    2
`define RAM_ST_FULL     3
`define RAM_ST_CNT      12:4

// preload image and the word shown for an undefined read
`define RAM_IMG_SEED    36'h5_a5c3_0f00
`define RAM_UNDEF_WORD  36'ha_aaaa_aaaa

`endif

// ==== src/ram_pkg.sv ====
/*
  Types of the configurable embedded memory block.
  Assumes ram_cfg.svh is reachable on the include path.
*/
`include "ram_cfg.svh"

package ram_pkg;

    typedef enum logic [2:0] {
        MM_SINGLE, MM_SIMPLE, MM_TRUE, MM_ROM, MM_FIFO, MM_SHIFT
    } mem_mode_t;

    typedef enum logic [1:0] {
        CK_INDEP, CK_IO, CK_RW, CK_SINGLE
    } clk_mode_t;

    typedef enum logic {
        ST_INIT, ST_RUN
    } seq_t;

    typedef enum logic [2:0] {
        RG_CTRL, RG_SHCFG, RG_STATUS, RG_PTR, RG_NONE
    } reg_sel_t;

    typedef struct packed {
        logic [31:0]         ctrl;
        logic [31:0]         shcfg;
        logic [31:0]         prdata;
        logic                slverr;
        logic [`RAM_AW-1:0]  ptr;
        logic [`RAM_AW-1:0]  wp;
        logic [`RAM_AW-1:0]  rp;
        logic [`RAM_CNTW-1:0] cnt;
        seq_t                st;
        logic [`RAM_AW-1:0]  init_idx;
        logic [`RAM_DW-1:0]  taps;
    } core_t;

    typedef struct packed {
        logic [`RAM_AW-1:0]  raddr;
        logic [`RAM_DW-1:0]  lat;
        logic [`RAM_DW-1:0]  oreg;
    } port_t;

endpackage

// ==== src/ram_tap_shift.sv ====
/*
  Shift-register segment mover: builds the next packed word of all tap
  segments and extracts the last segment for chaining.
  Assumes seg_w and seg_n were checked by the caller before use.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ram_cfg.svh"

module ram_tap_shift (
    // words
    input  wire logic [`RAM_DW-1:0] cur_word,
    input  wire logic [`RAM_DW-1:0] held_word,
    input  wire logic [`RAM_DW-1:0] shift_in,
    // geometry
    input  wire logic [5:0]         seg_w,
    input  wire logic [5:0]         seg_n,
    // results
    output logic      [`RAM_DW-1:0] next_word,
    output logic      [`RAM_DW-1:0] last_seg
);

    logic [`RAM_DW-1:0] mask_w;
    logic [`RAM_DW-1:0] mask_all;
    logic [11:0]        span;
    logic [11:0]        top_off;

    assign span    = {6'h00, seg_w} * {6'h00, seg_n};
    assign top_off = span - {6'h00, seg_w};

    genvar i;
    generate
        for (i = 0; i < `RAM_DW; i++) begin : g_mask
            assign mask_w[i]   = 12'(i) < {6'h00, seg_w};
            assign mask_all[i] = 12'(i) < span;
        end
    endgenerate

    // segment k moves to k+1; top one falls off as the tap [RULE27]
    assign next_word = ((cur_word << seg_w) | (shift_in & mask_w)) & mask_all;
    // oldest segment feeds the next block of a chain [RULE4]
    assign last_seg  = (held_word >> top_off) & mask_w;

endmodule
`default_nettype wire

// ==== src/ram_block.sv ====
/*
  Configurable embedded memory block with single-port, simple and true
  dual-port, ROM, FIFO and tapped shift-register modes, set over APB.
  Assumes one clock pclk; the clocking modes are carried by the per-group
  clock enables, and the user fabric drives the port pins.
*/
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "ram_cfg.svh"

module ram_block
    import ram_pkg::*;
(
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               clk_en,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [`RAM_PAW-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // asynchronous clears
    input  wire logic               aclr_a,
    input  wire logic               aclr_b,
    // port a
    input  wire logic [`RAM_AW-1:0] a_addr,
    input  wire logic [`RAM_DW-1:0] a_wdata,
    input  wire logic               a_we,
    input  wire logic               a_re,
    input  wire logic               a_in_ce,
    input  wire logic               a_out_ce,
    output logic      [`RAM_DW-1:0] a_q,
    // port b
    input  wire logic [`RAM_AW-1:0] b_addr,
    input  wire logic [`RAM_DW-1:0] b_wdata,
    input  wire logic               b_we,
    input  wire logic               b_re,
    input  wire logic               b_in_ce,
    input  wire logic               b_out_ce,
    output logic      [`RAM_DW-1:0] b_q,
    // shift register
    input  wire logic               shift_en,
    input  wire logic [`RAM_DW-1:0] shift_in,
    output logic      [`RAM_DW-1:0] taps,
    output logic      [`RAM_DW-1:0] cascade_out,
    // fifo flags
    output logic                    fifo_empty,
    output logic                    fifo_full
);

    ////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic mode_ok(mem_mode_t m, clk_mode_t k);
        logic ok;
        ok = 1'b0;
        unique case (k)
            CK_INDEP:  ok = (m == MM_TRUE) || (m == MM_ROM);
            CK_IO:     ok = (m == MM_TRUE) || (m == MM_SIMPLE) ||
                            (m == MM_SINGLE) || (m == MM_ROM);
            CK_RW:     ok = (m == MM_SIMPLE) || (m == MM_FIFO);
            CK_SINGLE: ok = (m <= MM_SHIFT);
        endcase
        return ok;
    endfunction

    // which enable gates a register group of one port
    function automatic logic grp_en(clk_mode_t k, logic out_side,
                                    logic pb, logic [1:0] cin,
                                    logic [1:0] cout);
        logic en;
        en = 1'b1;
        unique case (k)
            CK_INDEP:  en = cin[pb];                          // [RULE13] [RULE14]
            CK_IO:     en = out_side ? cout[pb] : cin[pb];    // [RULE15] [RULE16] [RULE17]
            CK_RW:     en = cin[pb];                          // [RULE18] [RULE19] [RULE20]
            CK_SINGLE: en = 1'b1;                             // [RULE21]
        endcase
        return en;
    endfunction

    // whether a port may write or read in a memory mode
    function automatic logic role(mem_mode_t m, logic pb, logic wr);
        logic r;
        r = 1'b0;
        unique case (m)
            MM_SINGLE: r = !pb;
            MM_SIMPLE: r = wr ? !pb : pb;
            MM_TRUE:   r = 1'b1;
            MM_ROM:    r = !wr;                               // [RULE5]
            MM_FIFO:   r = pb && !wr;
            MM_SHIFT:  r = 1'b0;
            default:   r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic reg_sel_t reg_sel(logic [`RAM_PAW-1:0] a);
        reg_sel_t s;
        s = RG_NONE;
        unique case (a)
            `RAM_OFF_CTRL:   s = RG_CTRL;
            `RAM_OFF_SHCFG:  s = RG_SHCFG;
            `RAM_OFF_STATUS: s = RG_STATUS;
            `RAM_OFF_PTR:    s = RG_PTR;
            default:         s = RG_NONE;
        endcase
        return s;
    endfunction

    function automatic logic [`RAM_DW-1:0] rom_image(logic [`RAM_AW-1:0] i);
        return {{(`RAM_DW-`RAM_AW){1'b0}}, i} ^ `RAM_IMG_SEED;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state and configuration

    localparam core_t CORE_RST = '{
        ctrl:     `RAM_CTRL_RST,
        shcfg:    `RAM_SHCFG_RST,
        prdata:   32'h0000_0000,
        slverr:   1'b0,
        ptr:      8'h00,
        wp:       8'h00,
        rp:       8'h00,
        cnt:      9'h000,
        st:       ST_INIT,
        init_idx: 8'h00,
        taps:     36'h0_0000_0000
    };

    logic [`RAM_DW-1:0] mem [0:`RAM_DEPTH-1];
    core_t              c_q;
    core_t              c_d;
    mem_mode_t          mode;
    clk_mode_t          ckm;
    logic [5:0]         sh_w;
    logic [5:0]         sh_n;
    logic [8:0]         sh_m;
    logic [11:0]        sh_wn;
    logic [20:0]        sh_bits;
    logic               shape_ok;
    logic               cfg_ok;
    logic               run;

    assign mode    = mem_mode_t'(c_q.ctrl[`RAM_CTRL_MODE]);
    assign ckm     = clk_mode_t'(c_q.ctrl[`RAM_CTRL_CLK]);
    assign sh_w    = c_q.shcfg[`RAM_SH_W];
    assign sh_n    = c_q.shcfg[`RAM_SH_N];
    assign sh_m    = c_q.shcfg[`RAM_SH_M];
    assign sh_wn   = {6'h00, sh_w} * {6'h00, sh_n};
    assign sh_bits = {9'h000, sh_wn} * {12'h000, sh_m};
    // bad geometry is flagged, never built [RULE1] [RULE2]
    assign shape_ok = (mode != MM_SHIFT) ||
                      ((sh_w != 6'h00) && (sh_n != 6'h00) &&
                       (sh_m != 9'h000) && (sh_m <= 9'(`RAM_DEPTH)) &&
                       (sh_wn <= 12'(`RAM_DW)) &&
                       (sh_bits <= 21'(`RAM_BITS)));
    assign cfg_ok  = mode_ok(mode, ckm) && shape_ok;          // [RULE12]
    assign run     = (c_q.st == ST_RUN) && cfg_ok && c_q.ctrl[`RAM_CTRL_EN];

    ////////////////////////////////////////////////////////////////////////
    // port decode

    logic [1:0]               cin;
    logic [1:0]               cout;
    logic [1:0]               aclr;
    logic [1:0]               we;
    logic [1:0]               re;
    logic [`RAM_AW-1:0]       addr  [0:1];
    logic [`RAM_DW-1:0]       wdata [0:1];
    logic [`RAM_DW-1:0]       q     [0:1];
    logic [1:0]               in_en;
    logic [1:0]               out_en;
    logic [1:0]               do_wr;
    logic [1:0]               do_rd;
    logic                     push;
    logic                     pop;
    logic                     shift_go;
    logic [`RAM_DW-1:0]       next_word;

    assign cin      = {b_in_ce, a_in_ce};
    assign cout     = {b_out_ce, a_out_ce};
    assign aclr     = {aclr_b, aclr_a};
    assign we       = {b_we, a_we};
    assign re       = {b_re, a_re};
    assign addr[0]  = a_addr;
    assign addr[1]  = b_addr;
    assign wdata[0] = a_wdata;
    assign wdata[1] = b_wdata;
    assign a_q      = q[0];
    assign b_q      = q[1];

    // fifo: a pushes, b pops; empty refuses the pop [RULE9] [RULE10]
    assign push = run && clk_en && in_en[0] && we[0] && (mode == MM_FIFO) &&
                  (c_q.cnt != `RAM_FULL_CNT);
    assign pop  = run && clk_en && in_en[1] && re[1] && (mode == MM_FIFO) &&
                  (c_q.cnt != 9'h000);
    assign shift_go = run && clk_en && shift_en && (mode == MM_SHIFT);

    ////////////////////////////////////////////////////////////////////////
    // per-port read path

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            port_t              pq;
            port_t              pd;
            logic               prst_n;
            logic [`RAM_AW-1:0] rd_addr;
            logic [`RAM_DW-1:0] old_word;
            logic [`RAM_DW-1:0] rdv;

            assign in_en[p]  = grp_en(ckm, 1'b0, 1'(p), cin, cout);
            assign out_en[p] = grp_en(ckm, 1'b1, 1'(p), cin, cout);
            assign do_wr[p]  = run && clk_en && in_en[p] && we[p] &&
                               role(mode, 1'(p), 1'b1);
            assign do_rd[p]  = run && clk_en && in_en[p] && re[p] &&
                               role(mode, 1'(p), 1'b0) &&
                               ((mode != MM_FIFO) || pop);
            assign rd_addr   = (mode == MM_FIFO) ? c_q.rp : addr[p];
            assign old_word  = mem[rd_addr];
            // only address and output stages see the clear [RULE11]
            assign prst_n    = presetn && !aclr[p];

            always_comb begin
                rdv = old_word;
                // same port first, then the far port [RULE22]
                if (do_wr[p] && (addr[p] == rd_addr)) begin
                    rdv = c_q.ctrl[`RAM_CTRL_NEWD] ? wdata[p] : old_word; // [RULE23]
                end else if (do_wr[1-p] && (addr[1-p] == rd_addr)) begin
                    if ((ckm == CK_INDEP) || (ckm == CK_RW)) begin
                        rdv = `RAM_UNDEF_WORD;                 // [RULE25]
                    end else begin
                        rdv = c_q.ctrl[`RAM_CTRL_MOLD] ? old_word
                                                         : `RAM_UNDEF_WORD; // [RULE24]
                    end
                end
            end

            always_comb begin
                pd = pq;
                if (do_rd[p]) begin
                    pd.raddr = rd_addr;                        // [RULE6]
                    pd.lat   = rdv;
                end
                if (clk_en && out_en[p]) begin
                    pd.oreg = pq.lat;
                end
            end

            // zero until the first read, preload or not [RULE26]
            always_ff @(posedge pclk or negedge prst_n) begin
                if (!prst_n) begin
                    pq <= '0;
                end else begin
                    pq <= pd;
                end
            end

            // rom reads share this path with single-port reads [RULE7] [RULE8]
            assign q[p] = c_q.ctrl[`RAM_CTRL_OREG] ? pq.oreg : pq.lat;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // shift segment mover

    ram_tap_shift u_tap_shift (
        .cur_word  (mem[c_q.ptr]),
        .held_word (c_q.taps),
        .shift_in  (shift_in),
        .seg_w     (sh_w),
        .seg_n     (sh_n),
        .next_word (next_word),
        .last_seg  (cascade_out)
    );

    assign taps = c_q.taps;                                   // [RULE3]

    ////////////////////////////////////////////////////////////////////////
    // array writes; no reset, the preload walk rewrites the array after reset

    always_ff @(posedge pclk) begin
        if (clk_en) begin
            if (c_q.st == ST_INIT) begin
                mem[c_q.init_idx] <= rom_image(c_q.init_idx); // [RULE5]
            end else begin
                if (shift_go) begin
                    mem[c_q.ptr] <= next_word;                // [RULE27]
                end
                if (push) begin
                    mem[c_q.wp] <= wdata[0];
                end
                for (int k = 0; k < 2; k++) begin
                    if (do_wr[k]) begin
                        mem[addr[k]] <= wdata[k];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control: preload walk, apb, fifo pointers, shift pointer

    reg_sel_t sel;
    logic     apb_setup;
    logic     apb_wr;

    assign sel       = reg_sel(paddr);
    assign apb_setup = psel && !penable;
    assign apb_wr    = psel && penable && pwrite && (sel != RG_NONE);

    always_comb begin
        c_d = c_q;
        if (clk_en) begin
            // preload walks the whole array once after reset
            if (c_q.st == ST_INIT) begin
                c_d.init_idx = c_q.init_idx + 8'h01;
                if (c_q.init_idx == `RAM_LAST_IDX) begin
                    c_d.st = ST_RUN;
                end
            end
            // read data is latched in setup so it leaves a flop
            if (apb_setup) begin
                c_d.slverr = (sel == RG_NONE);
                c_d.prdata = 32'h0000_0000;
                unique case (sel)
                    RG_CTRL:   c_d.prdata = c_q.ctrl;
                    RG_SHCFG:  c_d.prdata = c_q.shcfg;
                    RG_STATUS: begin
                        c_d.prdata[`RAM_ST_BUSY]   = (c_q.st == ST_INIT);
                        c_d.prdata[`RAM_ST_CFGERR] = !cfg_ok;
                        c_d.prdata[`RAM_ST_EMPTY]  = (c_q.cnt == 9'h000);
                        c_d.prdata[`RAM_ST_FULL]   = (c_q.cnt == `RAM_FULL_CNT);
                        c_d.prdata[`RAM_ST_CNT]    = c_q.cnt;
                    end
                    RG_PTR:    c_d.prdata = {24'h000000, c_q.ptr};
                    RG_NONE:   c_d.prdata = 32'h0000_0000;
                    default:   c_d.prdata = 32'h0000_0000;
                endcase
            end
            if (push) begin
                c_d.wp = c_q.wp + 8'h01;
            end
            if (pop) begin
                c_d.rp = c_q.rp + 8'h01;
            end
            c_d.cnt = c_q.cnt + {8'h00, push} - {8'h00, pop};
            if (shift_go) begin
                c_d.taps = mem[c_q.ptr];
                c_d.ptr  = (9'(c_q.ptr) == sh_m - 9'h001) ? 8'h00
                                                          : c_q.ptr + 8'h01;
            end
            // a new setup restarts the queue and the shift line
            if (apb_wr && ((sel == RG_CTRL) || (sel == RG_SHCFG))) begin
                if (sel == RG_CTRL) begin
                    c_d.ctrl = pwdata;
                end else begin
                    c_d.shcfg = pwdata;
                end
                c_d.wp   = 8'h00;
                c_d.rp   = 8'h00;
                c_d.cnt  = 9'h000;
                c_d.ptr  = 8'h00;
                c_d.taps = '0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c_q <= CORE_RST;
        end else begin
            c_q <= c_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // a frozen block stalls the bus rather than miss a write
    assign pready     = clk_en;
    assign pslverr    = psel && penable && c_q.slverr;
    assign prdata     = c_q.prdata;
    assign fifo_empty = (c_q.cnt == 9'h000);
    assign fifo_full  = (c_q.cnt == `RAM_FULL_CNT);

endmodule
`default_nettype wire

// ==== test/ram_block_monitor.sv ====
/* port checks of ram_block; assumes pclk, presetn low active */
`timescale 1ns/100ps
`default_nettype none
module ram_block_monitor (
    // clock, reset, apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    // ports
    input wire logic        aclr_a,
    input wire logic        aclr_b,
    input wire logic        shift_en,
    input wire logic [35:0] a_q,
    input wire logic [35:0] b_q,
    input wire logic [35:0] taps,
    input wire logic        fifo_empty,
    input wire logic        fifo_full
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////
    pready_follow_a: assert property (pready == clk_en)
        else $error("pready not clk_en");
    slverr_access_a: assert property (pslverr |-> psel && penable)
        else $error("slverr outside access");
    flags_apart_a: assert property (!(fifo_empty && fifo_full))
        else $error("empty and full");
    clear_port_a_a: assert property (aclr_a |-> a_q == 36'h0)
        else $error("a_q not cleared");
    clear_port_b_a: assert property (aclr_b |-> b_q == 36'h0)
        else $error("b_q not cleared");
    freeze_all_a: assert property (!clk_en |=> $stable(taps)
        && $stable(fifo_empty) && $stable(fifo_full))
        else $error("moved while frozen");
    taps_hold_a: assert property (!shift_en && !(psel && pwrite)
        |=> $stable(taps)) else $error("taps moved");
    boot_zero_a: assert property ($rose(presetn)
        |-> a_q == 36'h0 && b_q == 36'h0 && taps == 36'h0)
        else $error("outputs not zero");
endmodule
bind ram_block ram_block_monitor i_mon (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .pready,
    .pslverr, .aclr_a, .aclr_b, .shift_en, .a_q, .b_q, .taps,
    .fifo_empty, .fifo_full
);
`default_nettype wire

// ==== test/ram_fabric.sv ====
/* fabric model of port pins; assumes one request at a time */
`timescale 1ns/100ps
`default_nettype none
module ram_fabric (
    // clock
    input  wire logic        pclk,
    // port pins
    output logic      [7:0]  a_addr,
    output logic      [35:0] a_wdata,
    output logic             a_we,
    output logic             a_re,
    output logic      [7:0]  b_addr,
    output logic             b_we,
    output logic             b_re
);
    initial begin
        {a_addr, a_wdata, a_we, a_re, b_addr, b_we, b_re} = '0;
    end
    // idle lines inverted so stale data shows
    task automatic op(input logic [7:0] aa, ba, input logic [35:0] d,
                      input logic [3:0] en);
        @(posedge pclk);
        {a_addr, b_addr, a_wdata} <= {aa, ba, d};
        {a_we, a_re, b_we, b_re} <= en;
        @(posedge pclk);
        {a_addr, b_addr, a_wdata} <= ~{aa, ba, d};
        {a_we, a_re, b_we, b_re} <= 4'h0;
    endtask
endmodule
`default_nettype wire

// ==== test/ram_block_tb.sv ====
/* bench of ram_block; assumes the fabric model and monitor */
`timescale 1ns/100ps
`default_nettype none
`include "ram_cfg.svh"
module ram_block_tb;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, se;
    logic        aclr_a, aclr_b, shift_en, pready, pslverr;
    logic        fifo_empty, fifo_full, a_we, a_re, b_we, b_re;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  a_addr, b_addr;
    logic [35:0] a_wdata, a_q, b_q, shift_in, taps, cascade_out;
    logic [5:0]  ok [4];
    int          n_fail, check_count, i, j, k;
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    ram_block i_ram_block (
        .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .aclr_a, .aclr_b, .a_addr,
        .a_wdata, .a_we, .a_re, .a_in_ce(1'b1), .a_out_ce(1'b1), .a_q,
        .b_addr, .b_wdata(a_wdata), .b_we, .b_re, .b_in_ce(1'b1),
        .b_out_ce(1'b1), .b_q, .shift_en, .shift_in, .taps,
        .cascade_out, .fifo_empty, .fifo_full);
    ram_fabric u_fab (.pclk, .a_addr, .a_wdata, .a_we, .a_re, .b_addr,
        .b_we, .b_re);
    ////////////////////////////////////////////////
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int t;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 40);
        if (pready !== 1'b1) begin
            n_fail++;
            conclude;
        end
        {rd, se} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(36'(rd), 36'(e));
    endtask
    task automatic wc(input logic [31:0] d);
        apb(1'b1, `RAM_OFF_CTRL, d);
    endtask
    task automatic po(input logic [7:0] aa, ba, input logic [35:0] d,
                      input logic [3:0] en, input logic [35:0] e, pb);
        u_fab.op(aa, ba, d, en);
        #1;
        chk(pb[0] ? b_q : a_q, e);
    endtask
    task automatic conclude;
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, n_fail} = '0;
        {aclr_a, aclr_b, shift_en, shift_in, check_count} = '0;
        {presetn, clk_en} = 2'b01;
        ok = '{6'h0c, 6'h0f, 6'h12, 6'h3f};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`RAM_OFF_STATUS, 32'h5);
        rdchk(`RAM_OFF_SHCFG, `RAM_SHCFG_RST);
        repeat (256) @(posedge pclk);
        rdchk(`RAM_OFF_STATUS, 32'h4);
        rdchk(12'h010, 32'h0);
        chk(36'(se), 36'h1);
        u_fab.op(8'h05, 8'h00, 36'h11, 4'h8);
        po(8'h05, 8'h00, 36'h22, 4'hc, 36'h11, 1'b0);
        wc(32'h158);
        po(8'h05, 8'h00, 36'h33, 4'hc, 36'h33, 1'b0);
        wc(32'h19a);
        po(8'h09, 8'h09, 36'h44, 4'h9, 36'h9 ^ `RAM_IMG_SEED, 1'b1);
        wc(32'h11a);
        po(8'h09, 8'h09, 36'h55, 4'h9, `RAM_UNDEF_WORD, 1'b1);
        wc(32'h182);
        po(8'h09, 8'h09, 36'h66, 4'h9, `RAM_UNDEF_WORD, 1'b1);
        po(8'h00, 8'h09, 36'h0, 4'h1, 36'h66, 1'b1);
        wc(32'h15b);
        po(8'h07, 8'h00, 36'h77, 4'hc, 36'h7 ^ `RAM_IMG_SEED, 1'b0);
        wc(32'h17b);
        po(8'h03, 8'h00, 36'h0, 4'h4, 36'h7 ^ `RAM_IMG_SEED, 1'b0);
        @(posedge pclk);
        #1;
        chk(a_q, 36'h3 ^ `RAM_IMG_SEED);
        for (i = 0; i < 6; i++)
            for (k = 0; k < 4; k++) begin
                wc(32'h100 | 32'(k << 3) | 32'(i));
                rdchk(`RAM_OFF_STATUS, ok[k][i] ? 32'h4 : 32'h6);
            end
        wc(32'h11c);
        u_fab.op(8'h00, 8'h00, 36'h99, 4'h9);
        rdchk(`RAM_OFF_STATUS, 32'h10);
        for (i = 1; i < 257; i++)
            u_fab.op(8'h00, 8'h00, 36'(i), 4'h8);
        rdchk(`RAM_OFF_STATUS, 32'h1008);
        chk(36'({fifo_empty, fifo_full}), 36'h1);
        po(8'h00, 8'h00, 36'h0, 4'h1, 36'h99, 1'b1);
        clk_en <= 1'b0;
        po(8'h00, 8'h00, 36'h0, 4'h1, 36'h99, 1'b1);
        clk_en <= 1'b1;
        po(8'h00, 8'h00, 36'h0, 4'h1, 36'h1, 1'b1);
        apb(1'b1, `RAM_OFF_SHCFG, 32'h0003_0204);
        wc(32'h11d);
        for (j = 0; j < 10; j++) begin
            @(posedge pclk);
            shift_in <= 36'(j + 1);
            shift_en <= 1'b1;
            #1;
            if (j > 6) begin
                chk(taps, 36'((j - 6) << 4 | (j - 3)));
                chk(cascade_out, 36'(j - 6));
            end
        end
        @(posedge pclk);
        shift_en <= 1'b0;
        rdchk(`RAM_OFF_PTR, 32'h1);
        {aclr_a, aclr_b} <= 2'b11;
        @(posedge pclk);
        #1;
        chk(a_q | b_q, 36'h0);
        {aclr_a, aclr_b} <= 2'b00;
        rdchk(`RAM_OFF_CTRL, 32'h11d);
        conclude;
    end
endmodule
`default_nettype wire
